// ===== pkg/pss_map.vh
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
// Clock period in ps (250 MHz)
`define PSS_CLK_PERIOD_PS 4000
// Longest under-voltage to reset output delay, ns
`define PSS_UV_TO_RST_NS 250
// Cycles for that delay, rounded down
`define PSS_UV_TO_RST_CYC ((`PSS_UV_TO_RST_NS * 1000) / `PSS_CLK_PERIOD_PS)
// Sequencer states
`define PSS_ST_HOLD 3'h0
`define PSS_ST_DELAY 3'h1
`define PSS_ST_RUN 3'h2
`define PSS_ST_PARK 3'h3
`define PSS_ST_BRAKE 3'h4
// Spindle low-side driver count
`define PSS_LOW_SIDE_N 3
`endif

// ===== src/pss_uv_detect.v
`timescale 1ns/1ps
module pss_uv_detect (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Comparator results against the rising and falling references
   input wire sense_a_above_rise,
   input wire sense_a_above_fall,
   input wire sense_b_above_rise,
   input wire sense_b_above_fall,
   // Under-voltage level
   output wire under_voltage
);
   reg a_good_r;
   reg b_good_r;
   reg a_good_nxt;
   reg b_good_nxt;

   // Hysteresis: good once above rising ref, bad once below falling ref
   always @* begin
      a_good_nxt = a_good_r;
      b_good_nxt = b_good_r;
      if (a_good_r && !sense_a_above_fall) begin
         a_good_nxt = 1'b0;
      end else if (!a_good_r && sense_a_above_rise) begin
         a_good_nxt = 1'b1;
      end
      if (b_good_r && !sense_b_above_fall) begin
         b_good_nxt = 1'b0;
      end else if (!b_good_r && sense_b_above_rise) begin
         b_good_nxt = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         a_good_r <= 1'b0;
         b_good_r <= 1'b0;
      end else begin
         a_good_r <= a_good_nxt;
         b_good_r <= b_good_nxt;
      end
   end

   // Either input low means under voltage; falling edge seen same cycle
   assign under_voltage = !a_good_nxt || !b_good_nxt;
endmodule

// ===== src/pss_sequencer.v
`timescale 1ns/1ps
`include "pss_map.vh"
module pss_sequencer #(
   parameter LOW_SIDE_N = `PSS_LOW_SIDE_N
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Supply comparators
   input wire supply_sense_a_above_rise,
   input wire supply_sense_a_above_fall,
   input wire supply_sense_b_above_rise,
   input wire supply_sense_b_above_fall,
   // Delay indications
   input wire reset_delay_done,
   input wire brake_delay_done,
   // Delay timer controls
   output wire reset_delay_charge,
   output wire brake_delay_run,
   // Resets
   output wire sys_reset,
   output wire sys_reset_pin,
   // Drivers
   output wire actuator_enable,
   output wire spindle_enable,
   output wire park_enable,
   output wire [LOW_SIDE_N-1:0] spindle_low_side_on,
   // Status
   output wire under_voltage_flag
);
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg reset_r;
   reg park_r;
   reg brake_r;
   reg brake_run_r;
   reg drv_en_r;
   wire uv;

   pss_uv_detect u_uv (
      .clk(clk),
      .srst(srst),
      .sense_a_above_rise(supply_sense_a_above_rise),
      .sense_a_above_fall(supply_sense_a_above_fall),
      .sense_b_above_rise(supply_sense_b_above_rise),
      .sense_b_above_fall(supply_sense_b_above_fall),
      .under_voltage(uv)
   );

   always @* begin
      state_nxt = state_r;
      case (state_r)
         `PSS_ST_HOLD: begin
            if (!uv) begin
               state_nxt = `PSS_ST_DELAY;
            end
         end
         `PSS_ST_DELAY: begin
            if (uv) begin
               state_nxt = `PSS_ST_HOLD;
            end else if (reset_delay_done) begin
               state_nxt = `PSS_ST_RUN;
            end
         end
         `PSS_ST_RUN: begin
            if (uv) begin
               state_nxt = `PSS_ST_PARK;
            end
         end
         `PSS_ST_PARK: begin
            if (brake_delay_done) begin
               state_nxt = `PSS_ST_BRAKE;
            end
         end
         `PSS_ST_BRAKE: begin
            if (!uv) begin
               state_nxt = `PSS_ST_DELAY;
            end
         end
         default: begin
            state_nxt = `PSS_ST_HOLD;
         end
      endcase
   end

   always @(posedge clk) begin
      if (srst) begin
         state_r <= `PSS_ST_HOLD;
         reset_r <= 1'b1;
         park_r <= 1'b0;
         brake_r <= 1'b0;
         brake_run_r <= 1'b0;
         drv_en_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // Registered reset, one cycle after the detector, well inside limit
         reset_r <= (state_nxt != `PSS_ST_RUN);
         drv_en_r <= (state_nxt == `PSS_ST_RUN);
         park_r <= (state_nxt == `PSS_ST_PARK) ||
            (state_nxt == `PSS_ST_BRAKE);
         // Brake timer runs on stored charge regardless of supply
         brake_run_r <= (state_nxt == `PSS_ST_PARK);
         brake_r <= (state_nxt == `PSS_ST_BRAKE);
      end
   end

   assign reset_delay_charge = (state_r == `PSS_ST_DELAY);
   assign brake_delay_run = brake_run_r;
   assign sys_reset = reset_r;
   assign sys_reset_pin = reset_r;
   assign actuator_enable = drv_en_r;
   assign spindle_enable = drv_en_r;
   assign park_enable = park_r;
   assign spindle_low_side_on = {LOW_SIDE_N{brake_r}};
   assign under_voltage_flag = uv;
endmodule

// ===== test/pss_chk.sv
`timescale 1ns/1ps
module pss_chk #(parameter LOW_SIDE_N = 3) (
   // Watched ports
   input wire clk, srst, supply_sense_a_above_fall,
   input wire reset_delay_done, brake_delay_done,
   input wire reset_delay_charge, brake_delay_run,
   input wire sys_reset, sys_reset_pin, actuator_enable,
   input wire spindle_enable, park_enable, under_voltage_flag,
   input wire [LOW_SIDE_N-1:0] spindle_low_side_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   uv_rst_a: assert property (
      !supply_sense_a_above_fall |=> sys_reset) else $error("late reset");
   pin_eq_a: assert property (
      sys_reset_pin == sys_reset) else $error("pin differs");
   run_en_a: assert property (
      actuator_enable == !sys_reset && spindle_enable == actuator_enable)
      else $error("enable in reset");
   park_start_a: assert property (
      $rose(park_enable) |-> brake_delay_run && $past(actuator_enable))
      else $error("bad park start");
   brake_on_a: assert property (
      brake_delay_run && brake_delay_done
      |=> &spindle_low_side_on && !brake_delay_run) else $error("no brake");
   all_low_a: assert property (
      spindle_low_side_on == 0 || &spindle_low_side_on)
      else $error("partial brake");
   brake_hold_a: assert property (
      brake_delay_run && !brake_delay_done |=> brake_delay_run)
      else $error("brake delay cut");
   rel_cause_a: assert property (
      $fell(sys_reset) |-> $past(reset_delay_done) && $past(reset_delay_charge))
      else $error("early release");
   uv_hold_a: assert property (
      under_voltage_flag |=> sys_reset && !reset_delay_charge)
      else $error("delay in uv");
endmodule
bind pss_sequencer pss_chk #(.LOW_SIDE_N(LOW_SIDE_N)) u_chk (.*);

// ===== test/pss_dly_model.sv
`timescale 1ns/1ps
// Capacitor delays as cycle counts; done drops when released
module pss_dly_model #(parameter RD = 5, BD = 7) (
   input wire clk, reset_delay_charge, brake_delay_run,
   output wire reset_delay_done, brake_delay_done
);
   int rc = 0, bc = 0;
   always @(posedge clk) begin
      rc <= reset_delay_charge ? rc + 1 : 0;
      bc <= brake_delay_run ? bc + 1 : 0;
   end
   assign reset_delay_done = rc >= RD;
   assign brake_delay_done = bc >= BD;
endmodule

// ===== test/pss_sequencer_tb.sv
`timescale 1ns/1ps
module pss_sequencer_tb;
   logic clk = 0, srst = 1;
   logic [3:0] sn = 4'h0;
   wire reset_delay_done, brake_delay_done, reset_delay_charge;
   wire brake_delay_run, sys_reset, sys_reset_pin, actuator_enable;
   wire spindle_enable, park_enable, under_voltage_flag;
   wire [2:0] spindle_low_side_on;
   int errors = 0, compares = 0, cyc = 0;
   // Sense levels {a rise, a fall, b rise, b fall}, flag, reset
   logic [5:0] rows [6] = '{6'h17, 6'h3D, 6'h15, 6'h13, 6'h17, 6'h3D};
   pss_sequencer i_dut (.supply_sense_a_above_rise(sn[3]),
      .supply_sense_a_above_fall(sn[2]), .supply_sense_b_above_rise(sn[1]),
      .supply_sense_b_above_fall(sn[0]), .*);
   pss_dly_model i_pm (.*);
   initial forever #2 clk = ~clk;
   task chk(input logic [7:0] s, e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic v);
      for (int i = 0; i < 50 && sys_reset !== v; i++) @(negedge clk);
      chk(sys_reset, v);
   endtask
   task summarize;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         errors++;
         summarize;
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      srst = 0;
      chk({sys_reset, actuator_enable, spindle_low_side_on}, 5'h10);
      foreach (rows[i]) begin
         sn = rows[i][5:2];
         @(negedge clk);
         chk({under_voltage_flag, sys_reset}, rows[i][1:0]);
      end
      $display("rows done");
      wr(1'b0);
      chk({actuator_enable, spindle_enable, park_enable}, 3'h6);
      sn = 4'hB;
      @(negedge clk);
      chk({sys_reset, park_enable, brake_delay_run, actuator_enable},
         4'hE);
      sn = 4'hF;
      repeat (3) @(negedge clk);
      chk({park_enable, spindle_low_side_on}, 4'h8);
      for (int i = 0; i < 50 && !spindle_low_side_on[0]; i++) @(negedge clk);
      chk(spindle_low_side_on, 3'h7);
      wr(1'b0);
      $display("sequence done");
      srst = 1;
      @(negedge clk);
      srst = 0;
      chk({sys_reset, actuator_enable, park_enable, spindle_low_side_on},
         6'h20);
      wr(1'b0);
      $display("mid reset done");
      summarize;
   end
endmodule
